// ===== tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_SUBFRAME_ENTRY_KEY_PER_FRAME 100
`define TCC_SUBFRAME_ENTRY_KEY_TRIM_DEF 8'h01
`define TCC_FRAME_TRIM_DEF 8'h01
`define TCC_SEC_PER_MIN 60
`define TCC_MIN_PER_HOUR 60
`define TCC_NUM_REGS 8
`define TCC_OFST_REG 3'h5
`define TCC_MENU_OPTS 8
`define TCC_DIV_LAT 25
`endif

// ===== tcc_pkg.sv
package tcc_pkg;
    typedef struct packed {
        logic neg;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
        logic [7:0] frames;
        logic [7:0] subframes;
    } tcc_tc_t;
    typedef enum logic [3:0] {
        TCC_K_NONE = 4'h0,
        TCC_K_PLUS = 4'h1,
        TCC_K_MINUS = 4'h2,
        TCC_K_EQUALS = 4'h3,
        TCC_K_CLEAR = 4'h4,
        TCC_K_STORE = 4'h5,
        TCC_K_RECALL = 4'h6,
        TCC_K_REGSEL = 4'h7,
        TCC_K_ENTER = 4'h8,
        TCC_K_TRIM = 4'h9,
        TCC_K_SUBFRAME_ENTRY_KEY = 4'ha,
        TCC_K_JOG_UP = 4'hb,
        TCC_K_JOG_DN = 4'hc,
        TCC_K_SETUP = 4'hd
    } tcc_key_t;
    typedef struct packed {
        tcc_key_t key;
        logic [2:0] reg_sel;
        tcc_tc_t value;
    } tcc_cmd_t;
    typedef enum logic [2:0] {
        TCC_S_IDLE = 3'b000,
        TCC_S_TOFR = 3'b001,
        TCC_S_CALC = 3'b010,
        TCC_S_FMT = 3'b011,
        TCC_S_WAIT = 3'b100
    } tcc_state_t;
    typedef enum logic [1:0] {
        TCC_OP_NONE = 2'b00,
        TCC_OP_ADD = 2'b01,
        TCC_OP_SUB = 2'b10
    } tcc_op_t;
endpackage : tcc_pkg

// ===== tcc_regfile.sv
module tcc_regfile #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 41
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    initial begin
        if (DEPTH < 2) $error("tcc_regfile: depth too small");
    end
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    // registered read: data follows the address by one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : tcc_regfile

// ===== tcc_calc.sv
`include "tcc_cfg.svh"
// Overview of operation
// RL1: add operands as frame counts, master format
// RL2: carry oversized seconds and frames fields
// RL3: subtract operands as frame counts
// RL4: negative result when subtrahend is larger
// RL5: setup plus selects next menu option
// RL6: setup minus selects previous menu option
// RL7: trim plus adds trim value
// RL8: trim minus subtracts trim value
// RL9: clear abandons calculation, normal display
// RL10: store key then register writes result
// RL11: values kept with subframe resolution
// RL12: subframes hidden except error display; the code also shows them in subframe trim mode
// RL13: subframe trim of recalled offset
// RL14: subframe trim step defaults to one
// RL15: leaving trim commits offset automatically
// RL16: equals finishes and shows result
// RL17: clear or second store cancels store
// RL18: subframe trim borrows or carries frames
module tcc_calc #(
    parameter logic [7:0] FPS = 8'd30
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // key strobes
    input wire logic key_valid,
    input tcc_pkg::tcc_cmd_t key_cmd,
    // setup state
    input wire logic setup_mode,
    input wire logic error_display,
    input wire logic [7:0] subframe_entry_key_trim_step,
    input wire logic [7:0] frame_trim_step,
    // display and status
    output tcc_pkg::tcc_tc_t disp_q,
    output logic store_pending_q,
    output logic trim_mode_q,
    output logic subframe_entry_key_mode_q,
    output logic [2:0] menu_opt_q,
    output logic busy_q
);
    import tcc_pkg::*;
    localparam int SF = `TCC_SUBFRAME_ENTRY_KEY_PER_FRAME;
    initial begin
        if (FPS < 8'd24 || FPS > 8'd30) $error("tcc_calc: unsupported frame rate");
    end
    tcc_state_t state_q;
    tcc_op_t op_q;
    tcc_tc_t acc_q;
    tcc_tc_t entry_q;
    logic signed [31:0] a_sf_q;
    logic signed [31:0] b_sf_q;
    logic signed [31:0] res_q;
    logic [2:0] sel_q;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [40:0] rd_data;
    logic recall_q;
    tcc_tc_t result_q;
    // field-wise conversion carries any oversized field naturally
    function automatic logic signed [31:0] to_sf(input tcc_tc_t t);
        logic signed [31:0] v;
        v = 32'(t.hours) * 32'(FPS) * 32'd3600 + 32'(t.minutes) * 32'(FPS) * 32'd60
            + 32'(t.seconds) * 32'(FPS) + 32'(t.frames);
        v = v * SF + 32'(t.subframes);
        return t.neg ? -v : v;
    endfunction : to_sf
    // division by constants, done whole in the single TCC_S_CALC cycle; assumed small enough for one cycle at 50 MHz
    function automatic tcc_tc_t from_sf(input logic signed [31:0] s);
        tcc_tc_t t;
        logic [31:0] m;
        logic [31:0] fr;
        t = '0;
        t.neg = s < 0;
        m = t.neg ? 32'(-s) : 32'(s);
        t.subframes = 8'(m % SF);
        fr = m / SF;
        t.frames = 8'(fr % 32'(FPS));
        fr = fr / 32'(FPS);
        t.seconds = 8'(fr % 60);
        fr = fr / 60;
        t.minutes = 8'(fr % 60);
        t.hours = 8'(fr / 60);
        return t;
    endfunction : from_sf
    tcc_regfile #(.DEPTH(`TCC_NUM_REGS), .WIDTH(41)) u_regs (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(result_q),
        // address taken from the key itself so the registered read is ready when recall_q is
        .rd_addr(key_cmd.reg_sel),
        .rd_data(rd_data)
    );
    wire logic is_key = key_valid && state_q == TCC_S_IDLE;
    wire tcc_key_t k = key_cmd.key;
    // write on register selection while storing, or on trim exit
    assign wr_en = state_q == TCC_S_WAIT; // [RL10] [RL15]
    assign wr_addr = sel_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            menu_opt_q <= 3'h0;
        end else if (is_key && setup_mode && k == TCC_K_PLUS) begin
            menu_opt_q <= menu_opt_q + 3'h1; // [RL5]
        end else if (is_key && setup_mode && k == TCC_K_MINUS) begin
            menu_opt_q <= menu_opt_q - 3'h1; // [RL6]
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= TCC_S_IDLE;
            op_q <= TCC_OP_NONE;
            acc_q <= '0;
            entry_q <= '0;
            a_sf_q <= '0;
            b_sf_q <= '0;
            res_q <= '0;
            result_q <= '0;
            sel_q <= 3'h0;
            recall_q <= 1'b0;
            store_pending_q <= 1'b0;
            trim_mode_q <= 1'b0;
            subframe_entry_key_mode_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            case (state_q)
                TCC_S_IDLE: begin
                    busy_q <= 1'b0;
                    if (recall_q) begin
                        recall_q <= 1'b0;
                        entry_q <= rd_data; // [RL11]
                        result_q <= rd_data;
                    end else if (key_valid && !setup_mode) begin
                        case (k)
                            TCC_K_ENTER: entry_q <= key_cmd.value;
                            TCC_K_RECALL: begin
                                sel_q <= key_cmd.reg_sel;
                                recall_q <= 1'b1;
                            end
                            TCC_K_CLEAR: begin
                                op_q <= TCC_OP_NONE; // [RL9]
                                entry_q <= '0;
                                acc_q <= '0;
                                store_pending_q <= 1'b0; // [RL17]
                            end
                            TCC_K_STORE: store_pending_q <= !store_pending_q; // [RL17] [RL10]
                            TCC_K_REGSEL: begin
                                if (store_pending_q) begin
                                    sel_q <= key_cmd.reg_sel;
                                    // the entry buffer is what gets stored, not the last result
                                    result_q <= entry_q;
                                    state_q <= TCC_S_WAIT; // [RL10]
                                end
                            end
                            TCC_K_TRIM: begin
                                if (trim_mode_q) begin
                                    trim_mode_q <= 1'b0;
                                    subframe_entry_key_mode_q <= 1'b0;
                                    result_q <= entry_q;
                                    state_q <= TCC_S_WAIT; // [RL15]
                                end else begin
                                    trim_mode_q <= 1'b1;
                                end
                            end
                            TCC_K_SUBFRAME_ENTRY_KEY: subframe_entry_key_mode_q <= trim_mode_q && sel_q == `TCC_OFST_REG; // [RL13]
                            TCC_K_PLUS, TCC_K_MINUS, TCC_K_JOG_UP, TCC_K_JOG_DN: begin
                                busy_q <= 1'b1;
                                state_q <= TCC_S_TOFR;
                                if (trim_mode_q) begin
                                    a_sf_q <= to_sf(entry_q);
                                    // subframe steps default to one unless setup changes them [RL14]
                                    b_sf_q <= subframe_entry_key_mode_q ? 32'(subframe_entry_key_trim_step)
                                                           : 32'(frame_trim_step) * SF; // [RL13]
                                    op_q <= (k == TCC_K_PLUS || k == TCC_K_JOG_UP) ? TCC_OP_ADD // [RL7]
                                                                                  : TCC_OP_SUB; // [RL8]
                                end else if (k == TCC_K_PLUS || k == TCC_K_MINUS) begin
                                    acc_q <= entry_q;
                                    op_q <= k == TCC_K_PLUS ? TCC_OP_ADD : TCC_OP_SUB;
                                    state_q <= TCC_S_IDLE;
                                    busy_q <= 1'b0;
                                end else begin
                                    state_q <= TCC_S_IDLE;
                                    busy_q <= 1'b0;
                                end
                            end
                            TCC_K_EQUALS: begin
                                if (op_q != TCC_OP_NONE) begin
                                    a_sf_q <= to_sf(acc_q); // [RL2]
                                    b_sf_q <= to_sf(entry_q); // [RL2]
                                    busy_q <= 1'b1;
                                    state_q <= TCC_S_TOFR; // [RL16]
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                TCC_S_TOFR: begin
                    res_q <= op_q == TCC_OP_ADD ? a_sf_q + b_sf_q // [RL1]
                                                : a_sf_q - b_sf_q; // [RL3]
                    state_q <= TCC_S_CALC;
                end
                TCC_S_CALC: begin
                    // sign kept, never wrapped [RL4]; subframe overflow moves frames [RL18]
                    result_q <= from_sf(res_q);
                    state_q <= TCC_S_FMT;
                end
                TCC_S_FMT: begin
                    entry_q <= result_q; // [RL16] [RL1]
                    if (!trim_mode_q) begin
                        op_q <= TCC_OP_NONE;
                    end
                    state_q <= TCC_S_IDLE;
                end
                TCC_S_WAIT: begin
                    store_pending_q <= 1'b0;
                    state_q <= TCC_S_IDLE;
                end
                default: state_q <= TCC_S_IDLE;
            endcase
        end
    end
    // subframes are shown only in subframe trim mode or on error display, otherwise cleared
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            disp_q <= '0;
        end else begin
            disp_q <= entry_q;
            if (!error_display && !subframe_entry_key_mode_q) begin
                disp_q.subframes <= 8'h00; // [RL12]
            end
        end
    end
endmodule : tcc_calc

// ===== tcc_calc_checker.sv
`include "tcc_cfg.svh"
module tcc_calc_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // inputs
    input wire logic key_valid,
    input tcc_pkg::tcc_cmd_t key_cmd,
    input wire logic setup_mode,
    input wire logic error_display,
    input wire logic [7:0] subframe_entry_key_trim_step,
    input wire logic [7:0] frame_trim_step,
    // outputs
    input tcc_pkg::tcc_tc_t disp_q,
    input wire logic store_pending_q,
    input wire logic trim_mode_q,
    input wire logic subframe_entry_key_mode_q,
    input wire logic [2:0] menu_opt_q,
    input wire logic busy_q
);
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic tk;
    tcc_key_t k;
    assign tk = key_valid && !busy_q;
    assign k = key_cmd.key;
    property p_eq_busy; tk && k == TCC_K_EQUALS && !setup_mode |=> busy_q; endproperty
    a_eq_busy: assert property (p_eq_busy) else $error("equals did not start");
    property p_busy_len; $rose(busy_q) |-> ##[3:6] !busy_q; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_sto; tk && k == TCC_K_STORE && !setup_mode |=> store_pending_q != $past(store_pending_q); endproperty
    a_sto: assert property (p_sto) else $error("store did not toggle");
    property p_clr; tk && k == TCC_K_CLEAR && !setup_mode |=> !store_pending_q; endproperty
    a_clr: assert property (p_clr) else $error("clear kept store");
    property p_sel; tk && k == TCC_K_REGSEL && store_pending_q |=> ##[0:2] !store_pending_q; endproperty
    a_sel: assert property (p_sel) else $error("register select kept store");
    property p_up; tk && setup_mode && k == TCC_K_PLUS |=> menu_opt_q == $past(menu_opt_q) + 3'h1; endproperty
    a_up: assert property (p_up) else $error("menu not advanced");
    property p_dn; tk && setup_mode && k == TCC_K_MINUS |=> menu_opt_q == $past(menu_opt_q) - 3'h1; endproperty
    a_dn: assert property (p_dn) else $error("menu not moved back");
    property p_trim; tk && !setup_mode && k == TCC_K_TRIM |=> trim_mode_q != $past(trim_mode_q); endproperty
    a_trim: assert property (p_trim) else $error("trim key ignored");
    property p_sub;
        tk && trim_mode_q && k == TCC_K_SUBFRAME_ENTRY_KEY && key_cmd.reg_sel == `TCC_OFST_REG |=> subframe_entry_key_mode_q;
    endproperty
    a_sub: assert property (p_sub) else $error("subframe trim not entered");
    // one cycle of slack since the display is registered
    property p_hide; !error_display && !subframe_entry_key_mode_q && $past(!error_display && !subframe_entry_key_mode_q)
        |-> disp_q.subframes == 8'h00; endproperty
    a_hide: assert property (p_hide) else $error("subframes shown");
endmodule : tcc_calc_checker

// ===== tcc_keypad.sv
module tcc_keypad (
    // clock and status
    input wire logic mclk,
    input wire logic busy_q,
    // key strobes
    output logic key_valid,
    output tcc_pkg::tcc_cmd_t key_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;
    int hangs = 0;
    initial begin
        key_valid = 1'b0;
        key_cmd = '0;
    end
    task automatic press(input tcc_key_t k, input logic [2:0] s, input tcc_tc_t v);
        int n;
        @(posedge mclk);
        key_valid <= 1'b1;
        key_cmd <= '{key: k, reg_sel: s, value: v};
        @(posedge mclk);
        key_valid <= 1'b0;
        // released entry lines carry junk so a stale value cannot pass
        key_cmd.value <= ~v;
        // busy is looked at just after an edge, once it has settled
        repeat (3) @(posedge mclk);
        #1;
        n = 0;
        while (busy_q !== 1'b0 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (busy_q !== 1'b0) hangs++;
        @(posedge mclk);
        #1;
    endtask : press
endmodule : tcc_keypad

// ===== tcc_calc_tb.sv
`include "tcc_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;
    logic mclk, rst_n, key_valid, setup_mode, error_display, store_pending_q, trim_mode_q, subframe_entry_key_mode_q, busy_q;
    logic [7:0] subframe_entry_key_trim_step, frame_trim_step;
    logic [2:0] menu_opt_q;
    tcc_cmd_t key_cmd;
    tcc_tc_t disp_q;
    int failures = 0;
    int tests_run = 0;
    tcc_calc i_dut (.mclk, .rst_n, .key_valid, .key_cmd, .setup_mode, .error_display, .subframe_entry_key_trim_step,
        .frame_trim_step, .disp_q, .store_pending_q, .trim_mode_q, .subframe_entry_key_mode_q, .menu_opt_q, .busy_q);
    tcc_keypad i_kp (.mclk, .busy_q, .key_valid, .key_cmd);
    function automatic tcc_tc_t tc(logic n, logic [7:0] h, m, s, f, sf);
        return {n, h, m, s, f, sf};
    endfunction : tc
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic kp(input tcc_key_t k, input tcc_tc_t v = '0, input logic [2:0] s = 3'h0);
        i_kp.press(k, s, v);
        if (i_kp.hangs != 0) begin
            failures++;
            wrap_up();
        end
    endtask : kp
    task automatic calc(input tcc_tc_t a, input tcc_key_t op, input tcc_tc_t b, input tcc_tc_t exp);
        kp(TCC_K_ENTER, a);
        kp(op);
        kp(TCC_K_ENTER, b);
        kp(TCC_K_EQUALS);
        check(disp_q, exp);
    endtask : calc
    task automatic s_arith;
        calc(tc(0, 0, 1, 8'h41, 8'h2b, 0), TCC_K_PLUS, tc(0, 0, 2, 0, 8'h22, 0), tc(0, 0, 4, 7, 8'h11, 0));
        kp(TCC_K_STORE);
        check(store_pending_q, 1'b1);
        kp(TCC_K_REGSEL, '0, 3'h2);
        check(store_pending_q, 1'b0);
        calc(tc(0, 0, 1, 8'h41, 8'h2b, 0), TCC_K_MINUS, tc(0, 0, 2, 0, 8'h22, 0), tc(0, 0, 0, 5, 9, 0));
        calc(tc(0, 0, 2, 0, 8'h22, 0), TCC_K_MINUS, tc(0, 0, 1, 8'h41, 8'h2b, 0), tc(1, 0, 0, 5, 9, 0));
        kp(TCC_K_RECALL, '0, 3'h2);
        check(disp_q, tc(0, 0, 4, 7, 8'h11, 0));
    endtask : s_arith
    task automatic s_clear;
        kp(TCC_K_ENTER, tc(0, 0, 0, 0, 5, 0));
        kp(TCC_K_PLUS);
        kp(TCC_K_ENTER, tc(0, 0, 0, 0, 6, 0));
        kp(TCC_K_CLEAR);
        check(disp_q, tc(0, 0, 0, 0, 0, 0));
        calc(tc(0, 0, 0, 0, 3, 0), TCC_K_PLUS, tc(0, 0, 0, 0, 4, 0), tc(0, 0, 0, 0, 7, 0));
        kp(TCC_K_STORE);
        kp(TCC_K_STORE);
        check(store_pending_q, 1'b0);
        kp(TCC_K_STORE);
        kp(TCC_K_CLEAR);
        check(store_pending_q, 1'b0);
    endtask : s_clear
    task automatic s_trim;
        kp(TCC_K_RECALL, '0, 3'h2);
        kp(TCC_K_TRIM);
        check(trim_mode_q, 1'b1);
        kp(TCC_K_PLUS);
        check(disp_q, tc(0, 0, 4, 7, 8'h13, 0));
        kp(TCC_K_MINUS);
        kp(TCC_K_MINUS);
        check(disp_q, tc(0, 0, 4, 7, 8'h0f, 0));
        kp(TCC_K_TRIM);
        kp(TCC_K_ENTER, tc(0, 1, 8'h16, 8'h38, 9, 0));
        kp(TCC_K_STORE);
        kp(TCC_K_REGSEL, '0, `TCC_OFST_REG);
        kp(TCC_K_RECALL, '0, `TCC_OFST_REG);
        kp(TCC_K_TRIM);
        kp(TCC_K_SUBFRAME_ENTRY_KEY, '0, `TCC_OFST_REG);
        check(subframe_entry_key_mode_q, 1'b1);
        kp(TCC_K_MINUS);
        check(disp_q, tc(0, 1, 8'h16, 8'h38, 8, 8'h63));
        kp(TCC_K_JOG_UP);
        check(disp_q, tc(0, 1, 8'h16, 8'h38, 9, 0));
        kp(TCC_K_JOG_DN);
        kp(TCC_K_TRIM);
        check(trim_mode_q, 1'b0);
        @(posedge mclk);
        error_display <= 1'b1;
        kp(TCC_K_RECALL, '0, `TCC_OFST_REG);
        check(disp_q, tc(0, 1, 8'h16, 8'h38, 8, 8'h63));
        @(posedge mclk);
        error_display <= 1'b0;
    endtask : s_trim
    task automatic s_setup;
        @(posedge mclk);
        setup_mode <= 1'b1;
        kp(TCC_K_PLUS);
        kp(TCC_K_PLUS);
        kp(TCC_K_MINUS);
        check(menu_opt_q, 3'h1);
        @(posedge mclk);
        setup_mode <= 1'b0;
    endtask : s_setup
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        setup_mode = 1'b0;
        error_display = 1'b0;
        subframe_entry_key_trim_step = `TCC_SUBFRAME_ENTRY_KEY_TRIM_DEF;
        frame_trim_step = 8'h02;
        repeat (20) @(posedge mclk);
        #1;
        check({disp_q, store_pending_q, trim_mode_q, busy_q, menu_opt_q}, '0);
        @(posedge mclk);
        rst_n <= 1'b1;
        s_arith();
        s_clear();
        s_trim();
        s_setup();
        check(i_kp.hangs, 0);
        wrap_up();
    end
endmodule : testbench
bind tcc_calc tcc_calc_checker i_chk (.mclk, .rst_n, .key_valid, .key_cmd, .setup_mode, .error_display,
    .subframe_entry_key_trim_step, .frame_trim_step, .disp_q, .store_pending_q, .trim_mode_q, .subframe_entry_key_mode_q, .menu_opt_q, .busy_q);
